/* File: core/rxgc_pkg.sv */
// Purpose: shared constants for the receive gain and signal strength control
// Assumes: one 250 MHz clock, all state frozen while the clock enable is low
// Notes:   configuration word layout and timing counts live here only
package rxgc_pkg;
    // clock rate and documented times
    localparam int CLK_MHZ         = 250;
    localparam int AGC_DELAY_US    = 20;
    localparam int SQ_WINDOW_US    = 50;
    // least times round up; these are exact multiples anyway
    localparam int AGC_DELAY_CYC   = AGC_DELAY_US * CLK_MHZ;
    localparam int SQ_WINDOW_CYC   = SQ_WINDOW_US * CLK_MHZ;
    localparam int TIMER_W         = 14;

    // receiver configuration word fields
    localparam int CFG_AGC_EN_BIT  = 7;
    localparam int CFG_AGC_M_BIT   = 6;
    localparam int CFG_FILT_HI     = 5;
    localparam int CFG_FILT_LO     = 3;
    localparam int CFG_CUT_HI      = 2;
    localparam int CFG_CUT_LO      = 0;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // gain steps of 3 dB, seven at most
    localparam logic [2:0] STEP_MAX      = 3'h7;
    localparam logic [1:0] SQ_TRANS_MAX  = 2'h2;
    localparam logic [1:0] SQ_TRANS_SAT  = 2'h3;
    localparam logic [3:0] SUBPULSE_SPAN = 4'h8;
    localparam logic [3:0] RSSI_RESET    = 4'h0;

    // protocol mode and bit rate selection codes
    typedef enum logic [2:0] {
        RXGC_MODE_A106 = 3'h0,
        RXGC_MODE_A212 = 3'h1,
        RXGC_MODE_A424 = 3'h2,
        RXGC_MODE_A848 = 3'h3,
        RXGC_MODE_B106 = 3'h4,
        RXGC_MODE_B212 = 3'h5,
        RXGC_MODE_B424 = 3'h6,
        RXGC_MODE_B848 = 3'h7
    } rxgc_mode_e;

    // filter setting loaded for each mode
    function automatic logic [2:0] filter_for_mode(input logic [2:0] mode);
        case (mode)
            3'h0: filter_for_mode = 3'h0;
            3'h1: filter_for_mode = 3'h1;
            3'h2: filter_for_mode = 3'h2;
            3'h3: filter_for_mode = 3'h3;
            3'h4: filter_for_mode = 3'h4;
            3'h5: filter_for_mode = 3'h5;
            3'h6: filter_for_mode = 3'h6;
            default: filter_for_mode = 3'h7;
        endcase
    endfunction
endpackage

/* File: core/rxgc_gain_if.sv */
// Purpose: carries the three gain cut contributions and their combination
// Assumes: all signals on the block clock
// Notes:   counts are in 3 dB steps
interface rxgc_gain_if;
    logic [2:0] auto_steps;
    logic [2:0] squelch_steps;
    logic [2:0] manual_steps;
    logic [2:0] total;
    modport src (output auto_steps, output squelch_steps, output manual_steps, input total);
    modport sum (input auto_steps, input squelch_steps, input manual_steps, output total);
endinterface

/* File: core/rxgc_gain_sum.sv */
// Purpose: combines automatic, squelch and manual gain cut into one status
// Assumes: contributions change only on enabled clock edges
// Notes:   saturates instead of wrapping; result is registered
module rxgc_gain_sum (
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic ce,
    // gain contributions
    rxgc_gain_if.sum  gif
);
    logic [2:0] total;
    logic [2:0] next_total;

    // adds two step counts, clamping at the top step
    function automatic logic [2:0] sat_add(input logic [2:0] a, input logic [2:0] b);
        logic [3:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add = (s > {1'b0, rxgc_pkg::STEP_MAX}) ? rxgc_pkg::STEP_MAX : s[2:0];
    endfunction

    // three-way sum, clamped twice so no partial sum can wrap
    always_comb begin
        next_total = sat_add(sat_add(gif.auto_steps, gif.squelch_steps), gif.manual_steps);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            total <= 3'h0;
        end else if (ce) begin
            total <= next_total;
        end
    end

    assign gif.total = total;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // full three-way sum, so the manual field added to the other two can push it over the top
    property p_sum_saturates;
        ce && ({2'b0, gif.auto_steps} + {2'b0, gif.squelch_steps}
               + {2'b0, gif.manual_steps} > 5'h07)
            |=> total == rxgc_pkg::STEP_MAX;
    endproperty
    a_sum_saturates: assert property (p_sum_saturates)
        else $error("combined gain cut did not saturate");

    property p_sum_follows;
        ce && gif.squelch_steps == 3'h0 && gif.manual_steps == 3'h0
            |=> total == $past(gif.auto_steps);
    endproperty
    a_sum_follows: assert property (p_sum_follows)
        else $error("gain cut status does not follow automatic contribution");
endmodule // rxgc_gain_sum

/* File: core/rxgc_top.sv */
// Purpose: receive chain control: power, receive window, gain cut, signal strength
// Assumes: commands are one-cycle pulses from host logic on clk; comparator and
//          strength inputs come from the analog chain and are synchronised here
// Notes:   long timers are parameters so simulation can shorten them

// What this block does
// - receiver powered only while the receiver enable bit is one
// - receive window goes high after each transmit completes
// - unmask command forces the receive window high
// - bypass bit routes external demodulated input around the peak follower
// - mode write loads matching filter into configuration; software may overwrite
// - automatic gain steps down while the wide comparator still toggles
// - automatic gain starts 20 us after receive window rises
// - span bit zero: whole window; one: first eight subcarrier pulses only
// - automatic gain cut moves in seven 3 dB steps, 21 dB at most
// - automatic gain held in reset while receive window is low
// - squelch cuts 3 dB per 50 us window with over two transitions
// - clear squelch command removes squelch gain cut
// - three-bit manual cut field reduces gain in 3 dB steps
// - total gain cut combines all sources, shown as three-bit status
// - strength measure starts on window rise, runs while high, holds while low
// - strength is a peak hold from zero, only increasing
// - each automatic gain step zeroes strength and restarts measurement
// - strength is a four-bit value, 2.15 dB per step
// - clear strength command zeroes the value and restarts measurement
module rxgc_top #(
    parameter int AGC_DELAY_CYCLES = rxgc_pkg::AGC_DELAY_CYC,
    parameter int SQ_WINDOW_CYCLES = rxgc_pkg::SQ_WINDOW_CYC
) (
    // clock, reset, enable
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       ce,
    // operation control bits
    input  wire logic       rx_enable,
    input  wire logic       receiver_low_power,
    input  wire logic       peak_bypass_en,
    // configuration writes
    input  wire logic       mode_wr,
    input  wire logic [2:0] mode_wdata,
    input  wire logic       cfg_wr,
    input  wire logic [7:0] cfg_wdata,
    // events and direct commands, one-cycle pulses
    input  wire logic       tx_done,
    input  wire logic       rx_end,
    input  wire logic       cmd_unmask_rx,
    input  wire logic       cmd_squelch,
    input  wire logic       cmd_clear_squelch,
    input  wire logic       cmd_clear_rssi,
    // analog chain, asynchronous
    input  wire logic       wide_cmp,
    input  wire logic       dig_cmp,
    input  wire logic [3:0] rssi_sample,
    // outputs to analog chain
    output logic            rx_power,
    output logic            rx_low_power,
    output logic            peak_bypass,
    output logic            rx_window,
    // status
    output logic [7:0]      rxcfg,
    output logic [2:0]      gain_cut_status,
    output logic [3:0]      rssi,
    output logic            squelch_busy
);
    localparam int TW = rxgc_pkg::TIMER_W;
    localparam logic [TW-1:0] AGC_LOAD = TW'(AGC_DELAY_CYCLES);
    localparam logic [TW-1:0] SQ_LOAD  = TW'(SQ_WINDOW_CYCLES - 1);

    // synchronisers: stage one is read only by stage two
    logic       wide_s1, wide_s2, wide_s3;
    logic       dig_s1, dig_s2, dig_s3;
    logic [3:0] rssi_s1, rssi_s2, rssi_s3;

    // state
    logic          rx_window_q;
    logic [TW-1:0] agc_dly;
    logic          agc_live;
    logic [3:0]    subpulses;
    logic [2:0]    auto_steps;
    logic [TW-1:0] sq_timer;
    logic [1:0]    sq_trans;
    logic [2:0]    sq_steps;

    // next values
    logic          next_rx_power, next_rx_low_power, next_peak_bypass, next_rx_window;
    logic [7:0]    next_rxcfg;
    logic [TW-1:0] next_agc_dly;
    logic          next_agc_live;
    logic [3:0]    next_subpulses;
    logic [2:0]    next_auto_steps;
    logic [TW-1:0] next_sq_timer;
    logic [1:0]    next_sq_trans;
    logic [2:0]    next_sq_steps;
    logic          next_squelch_busy;
    logic [3:0]    next_rssi;

    // decoded conditions
    logic wide_edge, dig_edge, dig_rise, window_rise, agc_span_ok, agc_step;

    rxgc_gain_if gif ();

    assign wide_edge   = wide_s2 ^ wide_s3;
    assign dig_edge    = dig_s2 ^ dig_s3;
    assign dig_rise    = dig_s2 & ~dig_s3;
    assign window_rise = rx_window & ~rx_window_q;
    // span bit one limits gain action to the first subcarrier pulses
    assign agc_span_ok = ~rxcfg[rxgc_pkg::CFG_AGC_M_BIT]
                         | (subpulses < rxgc_pkg::SUBPULSE_SPAN);
    assign agc_step    = rx_window & agc_live & rxcfg[rxgc_pkg::CFG_AGC_EN_BIT] & agc_span_ok
                         & wide_edge & (auto_steps != rxgc_pkg::STEP_MAX);

    // control bits pass straight to the analog chain, registered
    always_comb begin
        next_rx_power     = rx_enable;
        next_rx_low_power = receiver_low_power;
        next_peak_bypass  = peak_bypass_en;
        // a software write of the whole word wins over the mode load
        if (cfg_wr) begin
            next_rxcfg = cfg_wdata;
        end else if (mode_wr) begin
            next_rxcfg = rxcfg;
            next_rxcfg[rxgc_pkg::CFG_FILT_HI:rxgc_pkg::CFG_FILT_LO] =
                rxgc_pkg::filter_for_mode(mode_wdata);
        end else begin
            next_rxcfg = rxcfg;
        end
    end

    // receive window: dropped when receiver is off or reception ends
    always_comb begin
        if (!rx_enable) begin
            next_rx_window = 1'b0;
        end else if (cmd_unmask_rx || tx_done) begin
            next_rx_window = 1'b1;
        end else if (rx_end) begin
            next_rx_window = 1'b0;
        end else begin
            next_rx_window = rx_window;
        end
    end

    // automatic gain: delayed start after window rise, reset while window low
    always_comb begin
        next_agc_dly    = agc_dly;
        next_agc_live   = agc_live;
        next_subpulses  = subpulses;
        next_auto_steps = auto_steps;
        if (!rx_window) begin
            next_agc_dly    = '0;
            next_agc_live   = 1'b0;
            next_subpulses  = 4'h0;
            next_auto_steps = 3'h0;
        end else if (window_rise) begin
            next_agc_dly  = AGC_LOAD;
            next_agc_live = 1'b0;
        end else if (agc_dly != '0) begin
            next_agc_dly  = agc_dly - 1'b1;
            next_agc_live = (agc_dly == TW'(1));
        end else begin
            if (agc_live && dig_rise && subpulses != rxgc_pkg::SUBPULSE_SPAN) begin
                next_subpulses = subpulses + 4'h1;
            end
            if (agc_step) begin
                next_auto_steps = auto_steps + 3'h1;
            end
        end
    end

    // squelch: count digitizer transitions per window, cut 3 dB while noisy
    always_comb begin
        logic [1:0] trans;
        trans             = sq_trans;
        next_sq_timer     = sq_timer;
        next_sq_trans     = sq_trans;
        next_sq_steps     = sq_steps;
        next_squelch_busy = squelch_busy;
        if (dig_edge && sq_trans != rxgc_pkg::SQ_TRANS_SAT) begin
            trans = sq_trans + 2'h1;
        end
        if (cmd_clear_squelch) begin
            next_sq_steps     = 3'h0;
            next_squelch_busy = 1'b0;
            next_sq_trans     = 2'h0;
            next_sq_timer     = '0;
        end else if (cmd_squelch) begin
            next_squelch_busy = 1'b1;
            next_sq_timer     = SQ_LOAD;
            next_sq_trans     = 2'h0;
        end else if (squelch_busy) begin
            next_sq_trans = trans;
            if (sq_timer != '0) begin
                next_sq_timer = sq_timer - 1'b1;
            end else if (trans > rxgc_pkg::SQ_TRANS_MAX && sq_steps != rxgc_pkg::STEP_MAX) begin
                next_sq_steps = sq_steps + 3'h1;
                next_sq_timer = SQ_LOAD;
                next_sq_trans = 2'h0;
            end else begin
                next_squelch_busy = 1'b0;
            end
        end
    end

    // signal strength peak hold; the clear command acts even while the receive window is low
    always_comb begin
        next_rssi = rssi;
        if (cmd_clear_rssi || (rx_window && (window_rise || agc_step))) begin
            next_rssi = rxgc_pkg::RSSI_RESET;
        // a multi-bit level may be torn mid-change; only two equal samples may raise the peak
        end else if (rx_window && rssi_s2 == rssi_s3 && rssi_s2 > rssi) begin
            next_rssi = rssi_s2;
        end
    end

    // single register stage for all state; ce freezes everything
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wide_s1 <= 1'b0; wide_s2 <= 1'b0; wide_s3 <= 1'b0;
            dig_s1  <= 1'b0; dig_s2  <= 1'b0; dig_s3  <= 1'b0;
            rssi_s1 <= 4'h0; rssi_s2 <= 4'h0; rssi_s3 <= 4'h0;
            rx_power     <= 1'b0;
            rx_low_power <= 1'b0;
            peak_bypass  <= 1'b0;
            rx_window    <= 1'b0;
            rx_window_q  <= 1'b0;
            rxcfg        <= rxgc_pkg::CFG_RESET;
            agc_dly      <= '0;
            agc_live     <= 1'b0;
            subpulses    <= 4'h0;
            auto_steps   <= 3'h0;
            sq_timer     <= '0;
            sq_trans     <= 2'h0;
            sq_steps     <= 3'h0;
            squelch_busy <= 1'b0;
            rssi         <= rxgc_pkg::RSSI_RESET;
        end else if (ce) begin
            wide_s1 <= wide_cmp; wide_s2 <= wide_s1; wide_s3 <= wide_s2;
            dig_s1  <= dig_cmp;  dig_s2  <= dig_s1;  dig_s3  <= dig_s2;
            rssi_s1 <= rssi_sample; rssi_s2 <= rssi_s1; rssi_s3 <= rssi_s2;
            rx_power     <= next_rx_power;
            rx_low_power <= next_rx_low_power;
            peak_bypass  <= next_peak_bypass;
            rx_window    <= next_rx_window;
            rx_window_q  <= rx_window;
            rxcfg        <= next_rxcfg;
            agc_dly      <= next_agc_dly;
            agc_live     <= next_agc_live;
            subpulses    <= next_subpulses;
            auto_steps   <= next_auto_steps;
            sq_timer     <= next_sq_timer;
            sq_trans     <= next_sq_trans;
            sq_steps     <= next_sq_steps;
            squelch_busy <= next_squelch_busy;
            rssi         <= next_rssi;
        end
    end

    // gain contributions combined in the saturating adder
    assign gif.auto_steps    = auto_steps;
    assign gif.squelch_steps = sq_steps;
    assign gif.manual_steps  = rxcfg[rxgc_pkg::CFG_CUT_HI:rxgc_pkg::CFG_CUT_LO];
    assign gain_cut_status   = gif.total;

    rxgc_gain_sum u_gain_sum (
        .clk  (clk),
        .nrst (nrst),
        .ce   (ce),
        .gif  (gif)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_power_follows;
        ce |=> rx_power == $past(rx_enable);
    endproperty
    a_power_follows: assert property (p_power_follows)
        else $error("receiver power does not follow enable");

    property p_tx_opens_window;
        ce && rx_enable && tx_done |=> rx_window;
    endproperty
    a_tx_opens_window: assert property (p_tx_opens_window)
        else $error("receive window not raised after transmit");

    property p_unmask_opens;
        ce && rx_enable && cmd_unmask_rx |=> rx_window;
    endproperty
    a_unmask_opens: assert property (p_unmask_opens)
        else $error("unmask command did not raise receive window");

    property p_bypass_follows;
        ce |=> peak_bypass == $past(peak_bypass_en);
    endproperty
    a_bypass_follows: assert property (p_bypass_follows)
        else $error("peak follower bypass does not follow its bit");

    property p_mode_loads_filter;
        ce && mode_wr && !cfg_wr
            |=> rxcfg[5:3] == rxgc_pkg::filter_for_mode($past(mode_wdata));
    endproperty
    a_mode_loads_filter: assert property (p_mode_loads_filter)
        else $error("mode write did not load filter setting");

    property p_agc_reset_low;
        ce && !rx_window |=> auto_steps == 3'h0 && !agc_live;
    endproperty
    a_agc_reset_low: assert property (p_agc_reset_low)
        else $error("automatic gain not held in reset");

    property p_agc_waits;
        agc_dly != '0 |-> auto_steps == 3'h0 && !agc_live;
    endproperty
    a_agc_waits: assert property (p_agc_waits)
        else $error("automatic gain acted before start delay");

    sequence s_sq_noisy_end;
        ce && squelch_busy && !cmd_squelch && !cmd_clear_squelch && sq_timer == '0
            && sq_trans == rxgc_pkg::SQ_TRANS_SAT && sq_steps != 3'h7;
    endsequence
    property p_squelch_step;
        s_sq_noisy_end |=> sq_steps == $past(sq_steps) + 3'h1 && squelch_busy;
    endproperty
    a_squelch_step: assert property (p_squelch_step)
        else $error("noisy squelch window did not cut gain");

    property p_clear_squelch;
        ce && cmd_clear_squelch |=> sq_steps == 3'h0 && !squelch_busy;
    endproperty
    a_clear_squelch: assert property (p_clear_squelch)
        else $error("clear squelch left gain cut");

    property p_rssi_hold;
        ce && !rx_window && !cmd_clear_rssi |=> rssi == $past(rssi);
    endproperty
    a_rssi_hold: assert property (p_rssi_hold)
        else $error("strength changed while window low");

    property p_rssi_peak;
        ce && rx_window && !window_rise && !agc_step && !cmd_clear_rssi |=> rssi >= $past(rssi);
    endproperty
    a_rssi_peak: assert property (p_rssi_peak)
        else $error("strength decreased during measurement");

    property p_rssi_agc_reset;
        ce && agc_step && !cmd_clear_rssi |=> rssi == 4'h0 && auto_steps == $past(auto_steps) + 3'h1;
    endproperty
    a_rssi_agc_reset: assert property (p_rssi_agc_reset)
        else $error("gain step did not restart strength");

    property p_rssi_clear;
        ce && cmd_clear_rssi |=> rssi == 4'h0;
    endproperty
    a_rssi_clear: assert property (p_rssi_clear)
        else $error("clear strength command ignored");
endmodule // rxgc_top

/* File: verif/rxgc_analog_model.sv */
// Purpose: analog receive chain stand-in: window comparators and strength level
// Assumes: bench picks which comparator toggles and the strength level
// Notes:   toggles every third cycle so a three-flop synchroniser sees every level
module rxgc_analog_model (
    // clock
    input  wire logic       clk,
    // selection from the bench
    input  wire logic       wide_on,
    input  wire logic       dig_on,
    input  wire logic [3:0] level,
    // comparator and strength outputs
    output logic            wide_cmp,
    output logic            dig_cmp,
    output logic [3:0]      rssi_sample
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph = 2'h0;
    initial begin
        wide_cmp = 1'b0;
        dig_cmp  = 1'b0;
    end
    // comparators hold their level while their input is quiet
    always @(negedge clk) begin
        ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
        if (ph == 2'h0) begin
            if (wide_on) wide_cmp <= ~wide_cmp;
            if (dig_on) dig_cmp <= ~dig_cmp;
        end
    end
    assign rssi_sample = level;
endmodule // rxgc_analog_model

/* File: verif/testbench.sv */
// Purpose: self-checking bench for the receive gain and strength control
// Assumes: timers shortened to 20 and 16 cycles; inputs driven on falling edges
// Notes:   expected values come from the documented behaviour only
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, nrst = 1'b0, ce = 1'b1;
    logic rx_enable = 1'b0, receiver_low_power = 1'b0, peak_bypass_en = 1'b0;
    logic mode_wr = 1'b0, cfg_wr = 1'b0;
    logic [2:0] mode_wdata = 3'h0;
    logic [7:0] cfg_wdata = 8'h00;
    logic tx_done = 1'b0, rx_end = 1'b0, cmd_unmask_rx = 1'b0;
    logic cmd_squelch = 1'b0, cmd_clear_squelch = 1'b0, cmd_clear_rssi = 1'b0;
    logic wide_on = 1'b0, dig_on = 1'b0;
    logic [3:0] level = 4'h0;
    logic wide_cmp, dig_cmp, rx_power, rx_low_power, peak_bypass, rx_window;
    logic squelch_busy;
    logic [3:0] rssi_sample, rssi;
    logic [7:0] rxcfg;
    logic [2:0] gain_cut_status;
    int err_total = 0, total_checks = 0, cycles = 0, n;
    always #2 clk = ~clk;
    rxgc_top #(.AGC_DELAY_CYCLES(20), .SQ_WINDOW_CYCLES(16)) i_dut (
        .clk(clk), .nrst(nrst), .ce(ce), .rx_enable(rx_enable),
        .receiver_low_power(receiver_low_power), .peak_bypass_en(peak_bypass_en),
        .mode_wr(mode_wr), .mode_wdata(mode_wdata), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
        .tx_done(tx_done), .rx_end(rx_end), .cmd_unmask_rx(cmd_unmask_rx),
        .cmd_squelch(cmd_squelch), .cmd_clear_squelch(cmd_clear_squelch),
        .cmd_clear_rssi(cmd_clear_rssi), .wide_cmp(wide_cmp), .dig_cmp(dig_cmp),
        .rssi_sample(rssi_sample), .rx_power(rx_power), .rx_low_power(rx_low_power),
        .peak_bypass(peak_bypass), .rx_window(rx_window), .rxcfg(rxcfg),
        .gain_cut_status(gain_cut_status), .rssi(rssi), .squelch_busy(squelch_busy));
    rxgc_analog_model i_analog (.clk(clk), .wide_on(wide_on), .dig_on(dig_on),
        .level(level), .wide_cmp(wide_cmp), .dig_cmp(dig_cmp), .rssi_sample(rssi_sample));
    // compare and count
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    // configuration write: mode code or full receiver configuration
    task wr(input logic is_mode, input logic [7:0] v);
        if (is_mode) begin
            mode_wr = 1'b1;
            mode_wdata = v[2:0];
        end else begin
            cfg_wr = 1'b1;
            cfg_wdata = v;
        end
        cyc(1);
        mode_wr = 1'b0;
        cfg_wr = 1'b0;
        // let an edge pass so a following write never re-raises a strobe in the same step
        cyc(1);
    endtask
    // one-cycle event: 0 tx, 1 end, 2 unmask, 3 squelch, 4 clear squelch, 5 clear rssi
    task cmd(input int k);
        case (k)
            0: tx_done = 1'b1;
            1: rx_end = 1'b1;
            2: cmd_unmask_rx = 1'b1;
            3: cmd_squelch = 1'b1;
            4: cmd_clear_squelch = 1'b1;
            default: cmd_clear_rssi = 1'b1;
        endcase
        cyc(1);
        {tx_done, rx_end, cmd_unmask_rx, cmd_squelch, cmd_clear_squelch, cmd_clear_rssi} = 6'h0;
    endtask
    // hang guard, far above the roughly one thousand cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            stop_test();
        end
    end
    initial begin
        cyc(4);
        nrst = 1'b1;
        chk({rxcfg[7:0]}, 8'h00);
        chk({rssi, 1'b0, gain_cut_status}, 8'h00);
        rx_enable = 1'b1;
        receiver_low_power = 1'b1;
        peak_bypass_en = 1'b1;
        cyc(1);
        chk({5'h0, rx_power, rx_low_power, peak_bypass}, 8'h07);
        for (int m = 0; m < 8; m++) begin
            wr(1'b1, 8'(m));
            chk(rxcfg, {2'h0, 3'(m), 3'h0});
        end
        wr(1'b0, 8'h2d);
        chk(rxcfg, 8'h2d);
        cyc(1);
        chk(gain_cut_status, 8'h05);
        // automatic gain on top of a manual cut of three steps
        wr(1'b0, 8'h83);
        wide_on = 1'b1;
        cmd(0);
        chk(rx_window, 8'h01);
        cyc(10);
        chk(gain_cut_status, 8'h03);
        cyc(200);
        chk(gain_cut_status, 8'h07);
        wide_on = 1'b0;
        cmd(1);
        chk(rx_window, 8'h00);
        cyc(3);
        chk(gain_cut_status, 8'h03);
        // span bit: one stops after eight subcarrier pulses, zero runs on
        for (int s = 1; s >= 0; s--) begin
            wr(1'b0, s ? 8'hc0 : 8'h80);
            dig_on = 1'b1;
            cmd(2);
            chk(rx_window, 8'h01);
            cyc(150);
            wide_on = 1'b1;
            cyc(100);
            chk(gain_cut_status, s ? 8'h00 : 8'h07);
            {wide_on, dig_on} = 2'h0;
            cmd(1);
            cyc(3);
        end
        // signal strength peak hold
        wr(1'b0, 8'h00);
        level = 4'h9;
        cmd(2);
        cyc(10);
        chk(rssi, 8'h09);
        level = 4'h4;
        cyc(10);
        chk(rssi, 8'h09);
        cmd(1);
        level = 4'hf;
        cyc(10);
        chk(rssi, 8'h09);
        cmd(5);
        cyc(3);
        chk(rssi, 8'h00);
        cmd(2);
        cyc(10);
        chk(rssi, 8'h0f);
        wr(1'b0, 8'h80);
        level = 4'h0;
        cyc(40);
        chk(rssi, 8'h0f);
        wide_on = 1'b1;
        cyc(20);
        chk(rssi, 8'h00);
        wide_on = 1'b0;
        cmd(1);
        // squelch with a noisy digitizer, then cleared, then quiet
        wr(1'b0, 8'h00);
        dig_on = 1'b1;
        for (int q = 0; q < 2; q++) begin
            cmd(3);
            n = 0;
            while (squelch_busy !== 1'b0 && n < 500) begin
                cyc(1);
                n++;
            end
            chk(squelch_busy, 8'h00);
            chk(gain_cut_status, q ? 8'h00 : 8'h07);
            dig_on = 1'b0;
            cmd(4);
            cyc(2);
            chk(gain_cut_status, 8'h00);
        end
        // clock enable low freezes the power bit even though enable drops
        ce = 1'b0;
        rx_enable = 1'b0;
        cyc(2);
        chk(rx_power, 8'h01);
        ce = 1'b1;
        cyc(1);
        chk(rx_power, 8'h00);
        stop_test();
    end
endmodule // testbench
